// ---- design/lisf_pkg.sv ----
// constants for the link input serialiser and fan-out block
// assumes a 250 MHz core clock (4000 ps period) and four deserialised links
package lisf_pkg;
	localparam int unsigned NLINK     = 4;
	localparam int unsigned WORD_W    = 10;
	localparam int unsigned FAN_W     = 5;
	localparam int unsigned EDGE_W    = 3;
	localparam int unsigned PHASES    = 4;
	localparam int unsigned ERRCNT_W  = 16;
	localparam int unsigned PIPE_AW   = 7;
	localparam int unsigned CLK_PS    = 4000;
	localparam int unsigned ONB_DLY_PS = 3120;
	// longest time rounds down, at least one cycle
	localparam int unsigned ONB_DLY_CYC =
		(ONB_DLY_PS / CLK_PS) < 1 ? 1 : (ONB_DLY_PS / CLK_PS);
	localparam logic [ERRCNT_W-1:0] ERRCNT_MAX = 16'hffff;
endpackage : lisf_pkg

// ---- design/lisf_top.sv ----
// link input serialiser and fan-out: realigns four links, masks, counts, fans out
// assumes link words and strobes are asynchronous and held stable a full link cycle
`timescale 1ns/100ps
module lisf_top (
	input  wire logic                                     i_clk,
	input  wire logic                                     i_rstn,
	input  wire logic [lisf_pkg::NLINK*lisf_pkg::WORD_W-1:0] i_link_data,
	input  wire logic [lisf_pkg::NLINK-1:0]               i_link_strobe,
	input  wire logic [lisf_pkg::NLINK-1:0]               i_link_lock,
	input  wire logic [lisf_pkg::NLINK-1:0]               i_link_mask,
	input  wire logic [lisf_pkg::NLINK-1:0]               i_errmap_clr,
	input  wire logic [lisf_pkg::PIPE_AW-1:0]             i_pipe_raddr,
	output logic      [lisf_pkg::FAN_W-1:0]               o_fan_backplane,
	output logic      [lisf_pkg::FAN_W-1:0]               o_fan_onboard,
	output logic      [lisf_pkg::EDGE_W-1:0]              o_fan_edge,
	output logic                                          o_lock_led,
	output logic      [lisf_pkg::NLINK-1:0]               o_lock_sync,
	output logic      [lisf_pkg::NLINK-1:0]               o_errmap,
	output logic      [lisf_pkg::NLINK*lisf_pkg::ERRCNT_W-1:0] o_errcnt,
	output logic      [lisf_pkg::NLINK*lisf_pkg::WORD_W-1:0] o_pipe_rdata
);
	localparam int unsigned N = lisf_pkg::NLINK;
	localparam int unsigned W = lisf_pkg::WORD_W;

	// ----------------------------------------
	// link capture and realignment
	// ----------------------------------------
	// strobe passes two flops; data is sampled only after a strobe edge is seen,
	// by which time the word has settled (the limitation: words must hold a cycle)
	logic [N-1:0]   stb_s1_q, stb_s2_q, stb_s3_q, lock_s1_q, lock_s2_q;
	logic [N*W-1:0] word_q;
	logic [N-1:0]   msk_s1_q, msk_s2_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stb_s1_q  <= '0;
			stb_s2_q  <= '0;
			stb_s3_q  <= '0;
			lock_s1_q <= '0;
			lock_s2_q <= '0;
			msk_s1_q  <= '0;
			msk_s2_q  <= '0;
		end else begin
			stb_s1_q  <= i_link_strobe;
			stb_s2_q  <= stb_s1_q;
			stb_s3_q  <= stb_s2_q;
			lock_s1_q <= i_link_lock;
			lock_s2_q <= lock_s1_q;
			msk_s1_q  <= i_link_mask;
			msk_s2_q  <= msk_s1_q;
		end
	end

	logic [N-1:0] stb_rise;
	assign stb_rise = stb_s2_q & ~stb_s3_q;

	// data bus held a full link period, so sampling on the synchronised edge is safe
	logic [N*W-1:0] dat_s1_q, dat_s2_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dat_s1_q <= '0;
			dat_s2_q <= '0;
		end else begin
			dat_s1_q <= i_link_data;
			dat_s2_q <= dat_s1_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			word_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (stb_rise[i]) begin
					// masked link delivers zeros
					word_q[i*W +: W] <= msk_s2_q[i] ? '0 : dat_s2_q[i*W +: W];
				end
			end
		end
	end

	// ----------------------------------------
	// lock monitor and error counting
	// ----------------------------------------
	logic [N-1:0]                err_q;
	logic [N*lisf_pkg::ERRCNT_W-1:0] cnt_q;
	logic [N-1:0]                errev;

	// error events wait until the lock synchroniser holds real samples, so that
	// reset release does not log a false unlock on every link
	logic [1:0] arm_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			arm_q <= '0;
		end else begin
			arm_q <= {arm_q[0], 1'b1};
		end
	end
	assign errev = ~lock_s2_q & ~msk_s2_q & {N{arm_q[1]}};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			err_q <= '0;
		end else begin
			// set wins over clear
			err_q <= (err_q & ~i_errmap_clr) | errev;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				// saturates so a dead link cannot wrap back to a healthy-looking count
				if (errev[i] && cnt_q[i*lisf_pkg::ERRCNT_W +: lisf_pkg::ERRCNT_W]
						!= lisf_pkg::ERRCNT_MAX) begin
					cnt_q[i*lisf_pkg::ERRCNT_W +: lisf_pkg::ERRCNT_W] <=
						cnt_q[i*lisf_pkg::ERRCNT_W +: lisf_pkg::ERRCNT_W] + 1'b1;
				end
			end
		end
	end

	logic led_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			led_q <= 1'b0;
		end else begin
			led_q <= |lock_s2_q;
		end
	end

	assign o_lock_led  = led_q;
	assign o_lock_sync = lock_s2_q;
	assign o_errmap    = err_q;
	assign o_errcnt    = cnt_q;

	// ----------------------------------------
	// fan-out multiplexing
	// ----------------------------------------
	// a 2-bit phase stands in for the 160 MHz output clock: four slots per word
	typedef enum logic [1:0] {
		LISF_PH0 = 2'b00,
		LISF_PH1 = 2'b01,
		LISF_PH2 = 2'b11,
		LISF_PH3 = 2'b10
	} lisf_phase_t;
	lisf_phase_t ph_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_q <= LISF_PH0;
		end else begin
			case (ph_q)
				LISF_PH0: ph_q <= LISF_PH1;
				LISF_PH1: ph_q <= LISF_PH2;
				LISF_PH2: ph_q <= LISF_PH3;
				LISF_PH3: ph_q <= LISF_PH0;
				default:  ph_q <= LISF_PH0;
			endcase
		end
	end

	// each slot XORs two links' 5-bit halves; slots 0..3 = links 0^1 lo, 0^1 hi, 2^3 lo, 2^3 hi
	logic [lisf_pkg::FAN_W-1:0] slot;
	always_comb begin
		case (ph_q)
			LISF_PH0: slot = word_q[0*W +: lisf_pkg::FAN_W] ^ word_q[1*W +: lisf_pkg::FAN_W];
			LISF_PH1: slot = word_q[0*W+5 +: lisf_pkg::FAN_W] ^ word_q[1*W+5 +: lisf_pkg::FAN_W];
			LISF_PH2: slot = word_q[2*W +: lisf_pkg::FAN_W] ^ word_q[3*W +: lisf_pkg::FAN_W];
			LISF_PH3: slot = word_q[2*W+5 +: lisf_pkg::FAN_W] ^ word_q[3*W+5 +: lisf_pkg::FAN_W];
			default:  slot = '0;
		endcase
	end

	logic [lisf_pkg::FAN_W-1:0] bp_q;
	logic [lisf_pkg::FAN_W-1:0] ob_dly_q [lisf_pkg::ONB_DLY_CYC];
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bp_q <= '0;
			for (int k = 0; k < lisf_pkg::ONB_DLY_CYC; k++) begin
				ob_dly_q[k] <= '0;
			end
		end else begin
			bp_q        <= slot;
			ob_dly_q[0] <= bp_q;
			for (int k = 1; k < lisf_pkg::ONB_DLY_CYC; k++) begin
				ob_dly_q[k] <= ob_dly_q[k-1];
			end
		end
	end

	// on-board path sits one clock behind the backplane path
	assign o_fan_backplane = bp_q;
	assign o_fan_onboard   = ob_dly_q[lisf_pkg::ONB_DLY_CYC-1];
	assign o_fan_edge      = bp_q[lisf_pkg::EDGE_W-1:0];

	// ----------------------------------------
	// read-out pipeline memory
	// ----------------------------------------
	logic [N*W-1:0]             pipe_mem [2**lisf_pkg::PIPE_AW];
	logic [lisf_pkg::PIPE_AW-1:0] wa_q;
	logic [N*W-1:0]             rd_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wa_q <= '0;
		end else if (ph_q == LISF_PH3) begin
			wa_q <= wa_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (ph_q == LISF_PH3) begin
			pipe_mem[wa_q] <= word_q;
		end
		rd_q <= pipe_mem[i_pipe_raddr];
	end
	assign o_pipe_rdata = rd_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_mask_zero;
		@(posedge i_clk) disable iff (!i_rstn)
		stb_rise[0] && msk_s2_q[0] |=> word_q[W-1:0] == '0;
	endproperty
	a_mask_zero: assert property (p_mask_zero) else $error("masked link not zero");

	property p_cnt_hold;
		@(posedge i_clk) disable iff (!i_rstn)
		msk_s2_q[0] |=> $stable(cnt_q[lisf_pkg::ERRCNT_W-1:0]);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("masked link counted");

	property p_err_set;
		@(posedge i_clk) disable iff (!i_rstn)
		errev[0] |=> err_q[0];
	endproperty
	a_err_set: assert property (p_err_set) else $error("error map not set");

	property p_cnt_inc;
		@(posedge i_clk) disable iff (!i_rstn)
		errev[0] && cnt_q[lisf_pkg::ERRCNT_W-1:0] != lisf_pkg::ERRCNT_MAX
		|=> cnt_q[lisf_pkg::ERRCNT_W-1:0] == $past(cnt_q[lisf_pkg::ERRCNT_W-1:0]) + 1'b1;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("error count missed");

	property p_led;
		@(posedge i_clk) disable iff (!i_rstn)
		(|lock_s2_q) |=> o_lock_led;
	endproperty
	a_led: assert property (p_led) else $error("lock indicator wrong");

	property p_lock_path;
		@(posedge i_clk) disable iff (!i_rstn)
		i_link_lock[0] [*3] |-> o_lock_sync[0];
	endproperty
	a_lock_path: assert property (p_lock_path) else $error("lock not forwarded");

	sequence s_ph_cycle;
		ph_q == LISF_PH0 ##1 ph_q == LISF_PH1 ##1 ph_q == LISF_PH2 ##1 ph_q == LISF_PH3;
	endsequence
	property p_phase;
		@(posedge i_clk) disable iff (!i_rstn)
		ph_q == LISF_PH0 |-> s_ph_cycle ##1 ph_q == LISF_PH0;
	endproperty
	a_phase: assert property (p_phase) else $error("phase sequence broken");

	property p_onb_delay;
		@(posedge i_clk) disable iff (!i_rstn)
		##1 o_fan_onboard == $past(o_fan_backplane, lisf_pkg::ONB_DLY_CYC);
	endproperty
	a_onb_delay: assert property (p_onb_delay) else $error("on-board delay wrong");

	property p_bp;
		@(posedge i_clk) disable iff (!i_rstn)
		##1 o_fan_backplane == $past(slot);
	endproperty
	a_bp: assert property (p_bp) else $error("backplane slot wrong");

	property p_clr;
		@(posedge i_clk) disable iff (!i_rstn)
		i_errmap_clr[0] && !errev[0] |=> !err_q[0];
	endproperty
	a_clr: assert property (p_clr) else $error("error map not cleared");

	property p_locked_quiet;
		@(posedge i_clk) disable iff (!i_rstn)
		lock_s2_q[0] |=> $stable(cnt_q[lisf_pkg::ERRCNT_W-1:0]);
	endproperty
	a_locked_quiet: assert property (p_locked_quiet) else $error("locked link counted");

	property p_led_off;
		@(posedge i_clk) disable iff (!i_rstn)
		!(|lock_s2_q) |=> !o_lock_led;
	endproperty
	a_led_off: assert property (p_led_off) else $error("lock indicator stuck on");

	property p_word_cap;
		@(posedge i_clk) disable iff (!i_rstn)
		stb_rise[1] && !msk_s2_q[1] |=> word_q[2*W-1:W] == $past(dat_s2_q[2*W-1:W]);
	endproperty
	a_word_cap: assert property (p_word_cap) else $error("link word not captured");

	property p_pipe_addr;
		@(posedge i_clk) disable iff (!i_rstn)
		ph_q == LISF_PH3 |=> wa_q == $past(wa_q) + 1'b1;
	endproperty
	a_pipe_addr: assert property (p_pipe_addr) else $error("pipeline address stalled");
endmodule : lisf_top

// ---- test/lisf_link_model.sv ----
// link model: four upstream links, each with its own free-running recovered strobe
// assumes the bench sets the words and lock requests; strobes never stop
`timescale 1ns/100ps
module lisf_link_model (
	input  wire logic [39:0] i_words,
	input  wire logic [3:0]  i_lock_req,
	output logic      [39:0] o_link_data,
	output logic      [3:0]  o_link_strobe,
	output logic      [3:0]  o_link_lock
);
	// ----------------------------------------
	// links
	// ----------------------------------------
	assign o_link_lock = i_lock_req;
	for (genvar g = 0; g < 4; g++) begin : g_link
		// periods differ, but each is a whole number of core clock periods, so no strobe drifts against it
		initial begin
			o_link_strobe[g] = 1'b0;
			o_link_data[g*10+:10] = 10'h000;
			// odd offset keeps link edges off the core clock edges
			#1;
			forever begin
				#(10 + 2 * g);
				o_link_strobe[g] = 1'b0;
				o_link_data[g*10+:10] = i_words[g*10+:10];
				#(10 + 2 * g);
				o_link_strobe[g] = 1'b1;
			end
		end
	end
endmodule : lisf_link_model

// ---- test/testbench.sv ----
// testbench for the link input serialiser and fan-out
// assumes the link model in front of the block; inputs change at the falling edge
`timescale 1ns/100ps
module testbench;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic [39:0] words = 40'h0;
	logic [3:0]  lock_req = 4'hf;
	logic [3:0]  i_link_mask = 4'h0;
	logic [3:0]  i_errmap_clr = 4'h0;
	logic [6:0]  i_pipe_raddr = 7'h00;
	logic [39:0] i_link_data;
	logic [3:0]  i_link_strobe;
	logic [3:0]  i_link_lock;
	logic [4:0]  o_fan_backplane;
	logic [4:0]  o_fan_onboard;
	logic [2:0]  o_fan_edge;
	logic        o_lock_led;
	logic [3:0]  o_lock_sync;
	logic [3:0]  o_errmap;
	logic [63:0] o_errcnt;
	logic [39:0] o_pipe_rdata;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	always #2 i_clk = ~i_clk;

	lisf_link_model i_lisf_link_model (.i_words(words), .i_lock_req(lock_req),
		.o_link_data(i_link_data), .o_link_strobe(i_link_strobe), .o_link_lock(i_link_lock));
	lisf_top i_lisf_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_data(i_link_data),
		.i_link_strobe(i_link_strobe), .i_link_lock(i_link_lock), .i_link_mask(i_link_mask),
		.i_errmap_clr(i_errmap_clr), .i_pipe_raddr(i_pipe_raddr),
		.o_fan_backplane(o_fan_backplane), .o_fan_onboard(o_fan_onboard),
		.o_fan_edge(o_fan_edge), .o_lock_led(o_lock_led), .o_lock_sync(o_lock_sync),
		.o_errmap(o_errmap), .o_errcnt(o_errcnt), .o_pipe_rdata(o_pipe_rdata));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc

	task conclude;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// a hang ends the run after about three times the expected length
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			conclude;
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_lock;
		check(o_errcnt, 64'h0);
		check(o_errmap, 4'h0);
		cyc(5);
		check(o_lock_sync, 4'hf);
		check(o_lock_led, 1'b1);
		lock_req = 4'hd;
		cyc(6);
		check(o_lock_sync, 4'hd);
		lock_req = 4'hf;
		cyc(6);
		check(o_errcnt, 64'h0000_0000_0006_0000);
		check(o_errmap, 4'h2);
	endtask : t_lock

	task t_mask_err;
		i_link_mask = 4'hf;
		cyc(4);
		lock_req = 4'h0;
		cyc(6);
		check(o_lock_led, 1'b0);
		check(o_errcnt, 64'h0000_0000_0006_0000);
		i_errmap_clr = 4'hf;
		cyc(1);
		i_errmap_clr = 4'h0;
		cyc(2);
		check(o_errmap, 4'h0);
		lock_req = 4'hf;
		cyc(4);
		i_link_mask = 4'h0;
	endtask : t_mask_err

	task t_fan(input logic [3:0] m);
		logic [4:0]  e [4];
		logic [39:0] w;
		logic [3:0]  hit;
		logic [4:0]  prev;
		i_link_mask = m;
		w = words;
		for (int k = 0; k < 4; k++)
			if (m[k])
				w[k*10+:10] = 10'h000;
		e[0] = w[4:0] ^ w[14:10];
		e[1] = w[9:5] ^ w[19:15];
		e[2] = w[24:20] ^ w[34:30];
		e[3] = w[29:25] ^ w[39:35];
		hit = 4'h0;
		cyc(20);
		prev = o_fan_backplane;
		repeat (8) begin
			cyc(1);
			check(o_fan_onboard, prev);
			check(o_fan_edge, o_fan_backplane[2:0]);
			for (int k = 0; k < 4; k++)
				if (o_fan_backplane === e[k])
					hit[k] = 1'b1;
			prev = o_fan_backplane;
		end
		check(hit, 4'hf);
	endtask : t_fan

	task t_pipe;
		cyc(520);
		i_pipe_raddr = 7'h05;
		cyc(2);
		check(o_pipe_rdata, words);
		i_pipe_raddr = 7'h7f;
		cyc(2);
		check(o_pipe_rdata, words);
	endtask : t_pipe

	initial begin
		cyc(8);
		i_rstn = 1'b1;
		cyc(1);
		words = {10'h250, 10'h1a9, 10'h044, 10'h3e1};
		t_lock;
		t_mask_err;
		t_fan(4'h1);
		t_fan(4'h0);
		t_pipe;
		conclude;
	end
endmodule : testbench
